//--- src/io_pass_regs.svh
/*
 * Constants of the I/O line passing output block: timing, limits, reset
 * values and configuration port selectors.
 * Assumes a 100 MHz system clock and the types in io_pass_pkg.
 */
// Notes on behaviour
// - Accepted sample drives matching digital outputs.
// - Analog channels zero/one set pulse outputs zero/one.
// - Forward accepted samples to host in modes 1,2.
// - Host forwarding switch 0/1, enabled after reset.
// - All-ones bound address disables line passing.
// - Bound address 0xFFFF accepts any addressed packet.
// - Bound-source sample updates every masked output-configured line not in pulse mode.
// - Bound source address is full 64 bits.
// - Digital lines 0-9 revert after hold expires.
// - Hold settings in 100 ms, max 0x1770, line holds reset zero.
// - Zero hold setting keeps passed value forever.
// - Peripheral lines 0-4 have identical hold timers.
// - Shared pulse timer zeroes duty; resets to 0xFF.
// - Pulse timer acts only in pulse-width mode.
// - Duty is ten bits, set by analog samples.
`ifndef IO_PASS_REGS_SVH
`define IO_PASS_REGS_SVH

// Hold tick in its own unit and the clock period it is counted in.
`define IOP_TICK_MS         100
`define IOP_CLK_PERIOD_NS   10
`define IOP_TICK_CYCLES     ((`IOP_TICK_MS * 1000000) / `IOP_CLK_PERIOD_NS)

// Line counts; the pulse-capable lines are peripheral lines zero and one.
`define IOP_NUM_DIG         10
`define IOP_NUM_LINES       15
`define IOP_PULSE_BASE      10

// Hold setting limit and reset values, in ticks, and the forwarding switch reset value.
`define IOP_HOLD_MAX        13'h1770
`define IOP_HOLD_RST        13'h0000
`define IOP_PULSE_HOLD_RST  13'h00FF
`define IOP_FWD_RST         1'b1

// Special bound source addresses.
`define IOP_ADDR_OFF        64'hFFFF_FFFF_FFFF_FFFF
`define IOP_ADDR_ANY        64'h0000_0000_0000_FFFF

// Framing modes that allow forwarding.
`define IOP_API_MODE_A      2'h1
`define IOP_API_MODE_B      2'h2

// Configuration selectors: 0..14 line holds, then pulse hold, then switch.
`define IOP_SEL_PULSE       5'h0F
`define IOP_SEL_FWD         5'h10

`endif

//--- src/io_pass_pkg.sv
/*
 * Types shared by the I/O line passing block.
 * Assumes the constants of io_pass_regs.svh.
 */
package io_pass_pkg;
    typedef logic [12:0] hold_t;   // Hold setting in 100 ms ticks.
    typedef logic [9:0]  duty_t;   // Pulse output duty cycle.
    typedef logic [63:0] addr_t;   // Source address of a remote module.

    // Hold timer states.
    typedef enum logic [1:0] {
        HOLD_IDLE  = 2'b00,
        HOLD_TIMED = 2'b01,
        HOLD_KEEP  = 2'b10
    } hold_state_t;
endpackage

//--- src/hold_tick_div.sv
/*
 * Divider that turns the system clock into a one-cycle tick enable.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module hold_tick_div #(
    parameter int unsigned CYCLES = 10000000
) (
    // Clock and reset.
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    // Tick enable.
    output logic      o_tick
);
    import io_pass_pkg::*;

    logic [23:0] cnt_ff;      // Cycles elapsed in the current tick.
    logic [23:0] nxt_cnt;     // Next count.
    logic        tick_ff;     // Registered tick pulse.
    logic        nxt_tick;    // Next tick pulse.

    // Wrap the count at the end of each period and pulse once.
    always_comb begin
        nxt_tick = (cnt_ff == 24'(CYCLES - 1));
        nxt_cnt  = nxt_tick ? 24'h000000 : cnt_ff + 24'h000001;
    end

    // Register the count.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            cnt_ff  <= 24'h000000;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign o_tick = tick_ff;
endmodule

//--- src/hold_timer.sv
/*
 * One hold timer: says whether a line still holds a passed value.
 * Assumes a one-cycle tick enable from hold_tick_div on the same clock.
 */
`timescale 1ns/1ps
module hold_timer (
    // Clock and reset.
    input  wire logic               i_clk_sys,
    input  wire logic               i_rst,
    // Tick and control.
    input  wire logic               i_tick,
    input  wire logic               i_enable,
    input  wire logic               i_load,
    input  wire io_pass_pkg::hold_t i_setting,
    // Status.
    output logic                    o_holding,
    output logic                    o_expire
);
    import io_pass_pkg::*;

    hold_state_t state_ff;    // Timer state.
    hold_state_t nxt_state;   // Next state.
    hold_t       cnt_ff;      // Ticks left.
    hold_t       nxt_cnt;     // Next ticks left.

    // A load always restarts from the setting, even mid-count.
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        o_expire  = 1'b0;
        if (i_load) begin
            nxt_state = (i_setting == 13'h0000) ? HOLD_KEEP : HOLD_TIMED;
            nxt_cnt   = i_setting;
        end else begin
            case (state_ff)
                HOLD_TIMED: begin
                    // Counting pauses while the timer is not enabled.
                    if (i_tick && i_enable) begin
                        nxt_cnt = cnt_ff - 13'h0001;
                        if (cnt_ff == 13'h0001) begin
                            nxt_state = HOLD_IDLE;
                            o_expire  = 1'b1;
                        end
                    end
                end
                HOLD_KEEP: nxt_state = HOLD_KEEP;
                HOLD_IDLE: nxt_state = HOLD_IDLE;
                default:   nxt_state = HOLD_IDLE;
            endcase
        end
    end

    // Register the timer.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_ff <= HOLD_IDLE;
            cnt_ff   <= 13'h0000;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    assign o_holding = (state_ff != HOLD_IDLE);

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    // Last tick of a timed hold ends it.
    property p_expiry;
        !i_load && state_ff == HOLD_TIMED && cnt_ff == 13'h0001 && i_tick && i_enable
            |=> !o_holding;
    endproperty
    a_expiry: assert property (p_expiry) else $error("hold did not end");

    // A zero setting never expires.
    property p_keep;
        i_load && i_setting == 13'h0000 |=> o_holding [*8];
    endproperty
    a_keep: assert property (p_keep) else $error("zero hold expired");

    // Disabled timer does not count.
    property p_paused;
        !i_enable && !i_load |=> $stable(cnt_ff);
    endproperty
    a_paused: assert property (p_paused) else $error("paused timer moved");
endmodule

//--- src/io_line_passing_outputs.sv
/*
 * Output side of I/O line passing: accepted remote samples drive the
 * local digital lines and the two pulse outputs, each held for a
 * configurable time, and may be forwarded to the host port.
 * Assumes samples arrive already decoded, one per cycle, from logic on
 * the same clock, and that the line configuration is stable settings.
 */
`timescale 1ns/1ps
`include "io_pass_regs.svh"
module io_line_passing_outputs #(
    parameter int unsigned HOLD_TICK_CYCLES = `IOP_TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rst,
    // Received sample.
    input  wire logic                 i_smp_valid,
    input  wire logic                 i_smp_to_us,
    input  wire io_pass_pkg::addr_t   i_smp_src_addr,
    input  wire logic [14:0]          i_smp_dio_mask,
    input  wire logic [14:0]          i_smp_dio,
    input  wire logic [1:0]           i_smp_adc_mask,
    input  wire io_pass_pkg::duty_t   i_analog_in_zero,
    input  wire io_pass_pkg::duty_t   i_analog_in_one,
    // Settings.
    input  wire io_pass_pkg::addr_t   i_bound_source_address,
    input  wire logic [1:0]           i_api_framing_mode,
    input  wire logic [14:0]          i_line_is_output,
    input  wire logic [14:0]          i_line_default,
    input  wire logic [1:0]           i_pulse_mode,
    // Hold settings and forwarding switch write port.
    input  wire logic                 i_cfg_wr,
    input  wire logic [4:0]           i_cfg_sel,
    input  wire io_pass_pkg::hold_t   i_cfg_data,
    // Line outputs.
    output logic [14:0]               o_line_level,
    output logic [14:0]               o_line_holding,
    output io_pass_pkg::duty_t        o_pulse_out_zero,
    output io_pass_pkg::duty_t        o_pulse_out_one,
    output logic                      o_host_forward_enable,
    // Forwarded sample towards the host port.
    output logic                      o_fwd_valid,
    output io_pass_pkg::addr_t        o_fwd_src_addr,
    output logic [14:0]               o_fwd_dio,
    output io_pass_pkg::duty_t        o_fwd_adc_zero,
    output io_pass_pkg::duty_t        o_fwd_adc_one
);
    import io_pass_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Acceptance.

    logic        passing_on;    // Line passing is not switched off.
    logic        addr_ok;       // Source passes the address filter.
    logic        accept;        // Sample is taken this cycle.
    logic [14:0] pwm_lines;     // Lines now acting as pulse outputs.
    logic [14:0] line_upd;      // Digital lines updated this cycle.
    logic [1:0]  pulse_upd;     // Pulse outputs updated this cycle.

    // Compare the whole 64-bit address; a partial compare would let
    // near-miss sources through.
    always_comb begin
        passing_on = (i_bound_source_address != `IOP_ADDR_OFF);
        addr_ok    = (i_bound_source_address == `IOP_ADDR_ANY) ||
                     (i_smp_src_addr == i_bound_source_address);
        accept     = i_smp_valid && i_smp_to_us && passing_on && addr_ok;
        pwm_lines  = 15'({i_pulse_mode, 10'h000});
        line_upd   = {15{accept}} & i_smp_dio_mask & i_line_is_output & ~pwm_lines;
        pulse_upd  = {2{accept}} & i_smp_adc_mask & i_pulse_mode;
    end

    ////////////////////////////////////////////////////////////////////////
    // Settings.

    hold_t hold_set_ff [16];   // Hold settings; entry 15 is the pulse one.
    hold_t nxt_hold_set [16];  // Next hold settings.
    logic  fwd_en_ff;          // Host forwarding switch.
    logic  nxt_fwd_en;         // Next switch value.

    // Out-of-range hold writes are dropped so the stored value stays legal.
    always_comb begin
        nxt_hold_set = hold_set_ff;
        nxt_fwd_en   = fwd_en_ff;
        if (i_cfg_wr) begin
            if (i_cfg_sel == `IOP_SEL_FWD) begin
                nxt_fwd_en = i_cfg_data[0];
            end else if (i_cfg_sel <= `IOP_SEL_PULSE && i_cfg_data <= `IOP_HOLD_MAX) begin
                nxt_hold_set[i_cfg_sel[3:0]] = i_cfg_data;
            end
        end
    end

    // Register the settings with their reset values.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            for (int i = 0; i < 15; i++) begin
                hold_set_ff[i] <= `IOP_HOLD_RST;
            end
            hold_set_ff[15] <= `IOP_PULSE_HOLD_RST;
            fwd_en_ff       <= `IOP_FWD_RST;
        end else begin
            hold_set_ff <= nxt_hold_set;
            fwd_en_ff   <= nxt_fwd_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Hold timers.

    logic        tick;        // 100 ms enable.
    logic [15:0] holding;     // Timer still holding.
    logic [15:0] expire;      // Timer ran out this cycle.
    logic [15:0] t_load;      // Timer restart.
    logic [15:0] t_enable;    // Timer may count.

    // The pulse timer counts only while a pulse-capable line is in that mode.
    assign t_load   = {|pulse_upd, line_upd};
    assign t_enable = {|i_pulse_mode, 15'h7FFF};

    hold_tick_div #(
        .CYCLES (HOLD_TICK_CYCLES)
    ) u_div (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .o_tick    (tick)
    );

    // Ten digital, five peripheral and the shared pulse timer.
    for (genvar g = 0; g < 16; g++) begin : g_timer
        hold_timer u_timer (
            .i_clk_sys (i_clk_sys),
            .i_rst     (i_rst),
            .i_tick    (tick),
            .i_enable  (t_enable[g]),
            .i_load    (t_load[g]),
            .i_setting (hold_set_ff[g]),
            .o_holding (holding[g]),
            .o_expire  (expire[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Line and pulse state.

    logic [14:0] passed_ff;   // Last passed digital values.
    logic [14:0] nxt_passed;  // Next passed values.
    logic [14:0] level_ff;    // Driven line levels.
    logic [14:0] nxt_level;   // Next line levels.
    duty_t       duty0_ff;    // Pulse output zero duty.
    duty_t       duty1_ff;    // Pulse output one duty.
    duty_t       nxt_duty0;   // Next duty zero.
    duty_t       nxt_duty1;   // Next duty one.
    logic        pulse_exp;   // Shared pulse timer ran out.

    // Lines not holding fall back to their configured value.
    always_comb begin
        nxt_passed = (passed_ff & ~line_upd) | (i_smp_dio & line_upd);
        nxt_level  = (passed_ff & holding[14:0]) | (i_line_default & ~holding[14:0]);
        pulse_exp  = expire[15];
        nxt_duty0  = duty0_ff;
        nxt_duty1  = duty1_ff;
        if (pulse_upd[0]) begin
            nxt_duty0 = i_analog_in_zero;
        end else if (pulse_exp) begin
            nxt_duty0 = 10'h000;
        end
        if (pulse_upd[1]) begin
            nxt_duty1 = i_analog_in_one;
        end else if (pulse_exp) begin
            nxt_duty1 = 10'h000;
        end
    end

    // Register line state.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            passed_ff <= 15'h0000;
            level_ff  <= 15'h0000;
            duty0_ff  <= 10'h000;
            duty1_ff  <= 10'h000;
        end else begin
            passed_ff <= nxt_passed;
            level_ff  <= nxt_level;
            duty0_ff  <= nxt_duty0;
            duty1_ff  <= nxt_duty1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host forwarding.

    logic  fwd_ok;             // Forwarding allowed for this sample.
    logic  fwd_valid_ff;       // Forward pulse.
    addr_t fwd_addr_ff;        // Forwarded source address.
    logic [14:0] fwd_dio_ff;   // Forwarded digital values.
    duty_t fwd_a0_ff;          // Forwarded analog zero.
    duty_t fwd_a1_ff;          // Forwarded analog one.

    // The host sink has no stall: one frame per accepted sample while the switch is on in mode 1 or 2.
    assign fwd_ok = accept && fwd_en_ff && (i_api_framing_mode == `IOP_API_MODE_A ||
                                            i_api_framing_mode == `IOP_API_MODE_B);

    // Capture the forwarded sample.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            fwd_valid_ff <= 1'b0;
            fwd_addr_ff  <= 64'h0000_0000_0000_0000;
            fwd_dio_ff   <= 15'h0000;
            fwd_a0_ff    <= 10'h000;
            fwd_a1_ff    <= 10'h000;
        end else begin
            fwd_valid_ff <= fwd_ok;
            if (fwd_ok) begin
                fwd_addr_ff <= i_smp_src_addr;
                fwd_dio_ff  <= i_smp_dio;
                fwd_a0_ff   <= i_analog_in_zero;
                fwd_a1_ff   <= i_analog_in_one;
            end
        end
    end

    assign o_line_level          = level_ff;
    assign o_line_holding        = holding[14:0];
    assign o_pulse_out_zero      = duty0_ff;
    assign o_pulse_out_one       = duty1_ff;
    assign o_host_forward_enable = fwd_en_ff;
    assign o_fwd_valid           = fwd_valid_ff;
    assign o_fwd_src_addr        = fwd_addr_ff;
    assign o_fwd_dio             = fwd_dio_ff;
    assign o_fwd_adc_zero        = fwd_a0_ff;
    assign o_fwd_adc_one         = fwd_a1_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    // Passed digital value reaches the pin two cycles later.
    property p_dig;
        line_upd[0] |=> ##1 o_line_level[0] == $past(i_smp_dio[0], 2);
    endproperty
    a_dig: assert property (p_dig) else $error("digital value not passed");

    // Analog channel zero sets pulse output zero.
    property p_ana;
        pulse_upd[0] |=> o_pulse_out_zero == $past(i_analog_in_zero);
    endproperty
    a_ana: assert property (p_ana) else $error("duty zero not passed");

    // Forward exactly when allowed.
    property p_fwd;
        o_fwd_valid == $past(i_smp_valid && i_smp_to_us && passing_on && addr_ok &&
            o_host_forward_enable && (i_api_framing_mode == `IOP_API_MODE_A ||
            i_api_framing_mode == `IOP_API_MODE_B));
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward mismatch");

    // Switch is on right after reset.
    property p_fwd_rst;
        @(posedge i_clk_sys) disable iff (1'b0) i_rst |=> o_host_forward_enable;
    endproperty
    a_fwd_rst: assert property (p_fwd_rst) else $error("forward off after reset");

    // Disabled passing keeps passed values and forwards nothing.
    property p_off;
        i_bound_source_address == `IOP_ADDR_OFF |=> $stable(passed_ff) && !o_fwd_valid;
    endproperty
    a_off: assert property (p_off) else $error("passing not disabled");

    // Wildcard accepts any addressed sample.
    property p_any;
        i_bound_source_address == `IOP_ADDR_ANY && i_smp_valid && i_smp_to_us |-> accept;
    endproperty
    a_any: assert property (p_any) else $error("wildcard refused");

    // A foreign source never updates a line.
    property p_match;
        i_smp_src_addr != i_bound_source_address &&
            i_bound_source_address != `IOP_ADDR_ANY |-> line_upd == 15'h0000;
    endproperty
    a_match: assert property (p_match) else $error("foreign source accepted");

    // Pulse timer expiry zeroes idle duty.
    property p_pexp;
        pulse_exp && !pulse_upd[1] |=> o_pulse_out_one == 10'h000;
    endproperty
    a_pexp: assert property (p_pexp) else $error("duty not cleared");

    // Illegal hold writes are ignored.
    property p_range;
        i_cfg_wr && i_cfg_sel == 5'h00 && i_cfg_data > `IOP_HOLD_MAX
            |=> $stable(hold_set_ff[0]);
    endproperty
    a_range: assert property (p_range) else $error("illegal hold stored");

    c_fwd:   cover property (fwd_ok);
    c_dexp:  cover property (expire[0]);
    c_pexp:  cover property (pulse_exp);
endmodule

//--- verification/remote_sample_src.sv
/*
 * Model of the remote radio module that sends I/O sample packets.
 * Assumes one rising-edge clock shared with the device under test.
 */
`timescale 1ns/1ps
module remote_sample_src (
    // Clock.
    input  wire logic        i_clk_sys,
    // Sample towards the device.
    output logic             o_valid,
    output logic             o_to_us,
    output logic [63:0]      o_src,
    output logic [14:0]      o_mask,
    output logic [14:0]      o_dio,
    output logic [1:0]       o_adc_mask,
    output logic [9:0]       o_analog_in_zero,
    output logic [9:0]       o_analog_in_one
);
    // Idle bus at time zero.
    initial begin
        o_valid    = 1'b0;
        o_to_us    = 1'b0;
        o_src      = 64'h0;
        o_mask     = 15'h0000;
        o_dio      = 15'h0000;
        o_adc_mask = 2'h0;
        o_analog_in_zero     = 10'h000;
        o_analog_in_one     = 10'h000;
    end

    // One sample for one cycle; it returns at the edge that takes it.
    // Afterwards the fields other than the analog mask are inverted, so stale data never looks valid.
    task automatic send_sample(input logic to_us, input logic [63:0] src,
                               input logic [14:0] mask, input logic [14:0] dio,
                               input logic [1:0] am, input logic [9:0] a0,
                               input logic [9:0] a1);
        @(posedge i_clk_sys);
        o_valid    <= 1'b1;
        o_to_us    <= to_us;
        o_src      <= src;
        o_mask     <= mask;
        o_dio      <= dio;
        o_adc_mask <= am;
        o_analog_in_zero     <= a0;
        o_analog_in_one     <= a1;
        @(posedge i_clk_sys);
        o_valid    <= 1'b0;
        o_to_us    <= ~to_us;
        o_src      <= ~src;
        o_mask     <= ~mask;
        o_dio      <= ~dio;
        o_analog_in_zero     <= ~a0;
        o_analog_in_one     <= ~a1;
    endtask
endmodule

//--- verification/testbench.sv
/*
 * Self-checking bench for io_line_passing_outputs and its remote sample model.
 * Assumes the hold tick is shortened to TICK cycles; the design carries
 * its own assertions.
 */
`timescale 1ns/1ps
`include "io_pass_regs.svh"
module testbench;
    import io_pass_pkg::*;
    localparam int unsigned TICK   = 4;  // Short tick keeps timer runs brief.
    localparam addr_t       ADDR_A = 64'h1122_3344_5566_7788;
    localparam addr_t       ADDR_B = 64'h0000_0000_0000_0042;
    logic i_clk_sys, i_rst, smp_valid, smp_to_us, cfg_wr;
    logic [14:0] smp_mask, smp_dio, line_out, line_def, lvl, holding;
    logic [1:0]  adc_mask, api_mode, pulse_mode;
    addr_t       smp_src, bound, fwd_src;
    duty_t       analog_in_zero, analog_in_one, pulse_out_zero, pulse_out_one, fwd_a0, fwd_a1;
    logic [4:0]  cfg_sel;
    hold_t       cfg_data;
    logic        fwd_en, fwd_valid;
    logic [14:0] fwd_dio;
    int          error_cnt, samples_checked, cyc;

    remote_sample_src remote_u (.i_clk_sys(i_clk_sys), .o_valid(smp_valid),
        .o_to_us(smp_to_us), .o_src(smp_src), .o_mask(smp_mask), .o_dio(smp_dio),
        .o_adc_mask(adc_mask), .o_analog_in_zero(analog_in_zero), .o_analog_in_one(analog_in_one));
    io_line_passing_outputs #(.HOLD_TICK_CYCLES(TICK)) dut_u (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_smp_valid(smp_valid),
        .i_smp_to_us(smp_to_us), .i_smp_src_addr(smp_src), .i_smp_dio_mask(smp_mask),
        .i_smp_dio(smp_dio), .i_smp_adc_mask(adc_mask), .i_analog_in_zero(analog_in_zero),
        .i_analog_in_one(analog_in_one), .i_bound_source_address(bound),
        .i_api_framing_mode(api_mode), .i_line_is_output(line_out),
        .i_line_default(line_def), .i_pulse_mode(pulse_mode), .i_cfg_wr(cfg_wr),
        .i_cfg_sel(cfg_sel), .i_cfg_data(cfg_data), .o_line_level(lvl),
        .o_line_holding(holding), .o_pulse_out_zero(pulse_out_zero), .o_pulse_out_one(pulse_out_one),
        .o_host_forward_enable(fwd_en), .o_fwd_valid(fwd_valid),
        .o_fwd_src_addr(fwd_src), .o_fwd_dio(fwd_dio), .o_fwd_adc_zero(fwd_a0),
        .o_fwd_adc_one(fwd_a1));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, and a cycle ceiling well above the few hundred cycles used.
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare one value and count it.
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    // Outputs are sampled at the falling edge, where they are settled.
    task automatic nedge(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    // Write one hold setting or the forwarding switch.
    task automatic cfg(input logic [4:0] sel, input hold_t data);
        @(posedge i_clk_sys);
        cfg_wr   <= 1'b1;
        cfg_sel  <= sel;
        cfg_data <= data;
        @(posedge i_clk_sys);
        cfg_wr   <= 1'b0;
    endtask
    // All-digital sample; forward pulse seen one cycle, level two after taking.
    task automatic send_chk(input addr_t src, input logic [14:0] dio,
                            input logic exp_fwd, input logic [14:0] exp_lvl);
        remote_u.send_sample(1'b1, src, 15'h7FFF, dio, 2'h0, 10'h000, 10'h000);
        nedge(1);
        check(fwd_valid, exp_fwd, "forward pulse");
        nedge(1);
        check(lvl, exp_lvl, "line levels");
    endtask
    // Wait a bounded number of cycles for a line's hold to end.
    task automatic wait_drop(input int idx, input int limit);
        int n;
        n = 0;
        while (holding[idx] !== 1'b0 && n < limit) begin
            nedge(1);
            n++;
        end
        check(holding[idx], 1'b0, "hold ended in time");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_reset();
        nedge(1);
        check({lvl, holding, pulse_out_zero, pulse_out_one, fwd_valid}, 0, "reset outputs");
        check(fwd_en, 1'b1, "switch after reset");
    endtask
    task automatic t_digital();
        send_chk(ADDR_A, 15'h2A5A, 1'b1, 15'h2A5A);
        check(fwd_src, ADDR_A, "forwarded source");
        check(fwd_dio, 15'h2A5A, "forwarded levels");
        nedge(40);
        check(lvl, 15'h2A5A, "zero setting keeps level");
    endtask
    task automatic t_filter();
        send_chk(ADDR_B, 15'h55A5, 1'b0, 15'h2A5A);
        @(posedge i_clk_sys);
        bound <= `IOP_ADDR_ANY;
        send_chk(ADDR_B, 15'h55A5, 1'b1, 15'h55A5);
        @(posedge i_clk_sys);
        bound <= `IOP_ADDR_OFF;
        send_chk(`IOP_ADDR_OFF, 15'h2A5A, 1'b0, 15'h55A5);
        @(posedge i_clk_sys);
        bound <= ADDR_A;
    endtask
    task automatic t_forward();
        @(posedge i_clk_sys);
        api_mode <= 2'h0;
        send_chk(ADDR_A, 15'h0F0F, 1'b0, 15'h0F0F);
        @(posedge i_clk_sys);
        api_mode <= `IOP_API_MODE_B;
        send_chk(ADDR_A, 15'h70F0, 1'b1, 15'h70F0);
        cfg(`IOP_SEL_FWD, 13'h0000);
        nedge(2);
        check(fwd_en, 1'b0, "switch off");
        send_chk(ADDR_A, 15'h0F0F, 1'b0, 15'h0F0F);
        cfg(`IOP_SEL_FWD, 13'h0001);
        nedge(2);
        check(fwd_en, 1'b1, "switch on");
    endtask
    task automatic t_hold();
        cfg(5'h00, 13'h0004);
        cfg(5'h0C, 13'h0002);
        cfg(5'h01, 13'h0001);
        cfg(5'h01, 13'h1771); // Out of range, so line one keeps its one-tick setting.
        remote_u.send_sample(1'b1, ADDR_A, 15'h7FFF, 15'h6FFF, 2'h0, 10'h000, 10'h000);
        repeat (8) @(posedge i_clk_sys);
        remote_u.send_sample(1'b1, ADDR_A, 15'h0001, 15'h0001, 2'h0, 10'h000, 10'h000);
        nedge(10);
        check(holding[0], 1'b1, "restarted hold");
        check(holding[12], 1'b0, "peripheral hold ended");
        check(lvl[12], line_def[12], "peripheral line reverted");
        wait_drop(0, 20);
        nedge(1);
        check(lvl[0], line_def[0], "digital line reverted");
        check(holding[1], 1'b0, "out-of-range setting dropped");
    endtask
    task automatic t_pulse();
        remote_u.send_sample(1'b1, ADDR_A, 15'h0000, 15'h0000, 2'h3, 10'h3FF, 10'h155);
        nedge(3);
        check({pulse_out_zero, pulse_out_one}, 20'h0, "duty ignored out of pulse mode");
        @(posedge i_clk_sys);
        pulse_mode <= 2'h3;
        cfg(`IOP_SEL_PULSE, 13'h0002);
        remote_u.send_sample(1'b1, ADDR_A, 15'h0000, 15'h0000, 2'h3, 10'h3FF, 10'h155);
        nedge(2);
        check(pulse_out_zero, 10'h3FF, "pulse zero duty");
        check(pulse_out_one, 10'h155, "pulse one duty");
        check({fwd_a0, fwd_a1}, {10'h3FF, 10'h155}, "forwarded analog");
        nedge(20);
        check({pulse_out_zero, pulse_out_one}, 20'h0, "duty after shared timer");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Verdict in one place.
    task automatic give_verdict();
        $display("errors %0d, comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        error_cnt = 0;
        samples_checked = 0;
        cyc = 0;
        i_rst = 1'b1;
        cfg_wr = 1'b0;
        cfg_sel = 5'h00;
        cfg_data = 13'h0000;
        bound = ADDR_A;
        api_mode = `IOP_API_MODE_A;
        line_out = 15'h7FFF;
        line_def = 15'h1000;
        pulse_mode = 2'h0;
        repeat (20) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        t_reset();
        t_digital();
        t_filter();
        t_forward();
        t_hold();
        t_pulse();
        give_verdict();
    end
endmodule
